// >>> prog_entry_pkg.sv
package prog_entry_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned T_HALF_BIT_NS    = 100;
  localparam int unsigned T_ENTRY_NS       = 5000;
  localparam int unsigned T_CMD_DATA_NS    = 1000;
  localparam int unsigned T_CMD_GAP_NS     = 1000;
  // least times round up to whole cycles
  localparam int unsigned HALF_BIT_CYCLES  = (T_HALF_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ENTRY_CYCLES     = (T_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CMD_DATA_CYCLES  = (T_CMD_DATA_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CMD_GAP_CYCLES   = (T_CMD_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  PHASE_HALF       = 8'(HALF_BIT_CYCLES);
  localparam logic [7:0]  PHASE_LAST       = 8'(2 * HALF_BIT_CYCLES - 1);
  localparam logic [15:0] WAIT_ENTRY       = 16'(ENTRY_CYCLES - 1);
  localparam logic [15:0] WAIT_CMD_DATA    = 16'(CMD_DATA_CYCLES - 1);
  localparam logic [15:0] WAIT_CMD_GAP     = 16'(CMD_GAP_CYCLES - 1);

  // serial framing
  localparam int unsigned DATA_W           = 14;
  localparam int unsigned CMD_W            = 6;
  localparam logic [5:0]  KEY_LAST_BIT     = 6'h1f;
  localparam logic [5:0]  CMD_LAST_BIT     = 6'h05;
  localparam logic [5:0]  FRAME_LAST_BIT   = 6'h0f;
  localparam logic [31:0] LV_ENTRY_KEY     = 32'h5a3c96e1; // arbitrary value
  localparam int unsigned WR_FIFO_DEPTH    = 8;

  // configuration memory map of the device
  localparam logic [15:0] ADDR_USER_ID     = 16'h8000;
  localparam logic [15:0] ADDR_PART_ID     = 16'h8006;
  localparam logic [15:0] ADDR_CONFIG_ONE  = 16'h8007;
  localparam logic [15:0] ADDR_CONFIG_TWO  = 16'h8008;
  localparam logic [15:0] ADDR_CALIB_ONE   = 16'h8009;
  localparam logic [15:0] ADDR_CALIB_TWO   = 16'h800a;
  localparam int unsigned PART_ID_MSB      = 13;
  localparam int unsigned PART_ID_LSB      = 5;
  localparam int unsigned REVISION_MSB     = 4;
  localparam int unsigned REVISION_LSB     = 0;
  localparam int unsigned STACK_FAULT_BIT  = 9;
  localparam int unsigned LV_PROG_EN_BIT   = 13;
  // arbitrary expected part code, used by software only
  localparam logic [8:0]  EXPECTED_PART_ID = 9'h0a5;

  typedef enum logic [2:0] {
    OP_ENTER_VPP_FIRST = 3'h0,
    OP_ENTER_VDD_FIRST = 3'h1,
    OP_ENTER_LOW_VOLT  = 3'h2,
    OP_EXIT            = 3'h3,
    OP_COMMAND         = 3'h4
  } prog_op_e;

  typedef struct packed {
    prog_op_e          kind;
    logic [CMD_W-1:0]  cmd;
    logic              has_data;
    logic              is_read;
  } prog_op_s;

  typedef struct packed {
    logic clk;
    logic dat;
    logic dat_oe_n;
    logic vpp_en;
    logic master_clear_pin_low;
    logic vdd_en;
  } pin_drive_s;

endpackage

// >>> prog_sync2.sv
`timescale 1ns/100ps
module prog_sync2
  import prog_entry_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta  <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule

// >>> prog_word_fifo.sv
`timescale 1ns/100ps
module prog_word_fifo
  import prog_entry_pkg::*;
#(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 8
)(
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW:0]      next_count;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;
  assign out_data_out  = mem[rd_ptr];
  assign out_valid_out = (count != '0);

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr       <= '0;
      rd_ptr       <= '0;
      count        <= '0;
      in_ready_out <= 1'b1;
    end else begin
      count        <= next_count;
      // registered full flag keeps the ready port glitch free
      in_ready_out <= (next_count != (AW+1)'(DEPTH));
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule

// >>> prog_entry_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// RULE1 - identity word: part code bits 13..5, revision bits 4..0, read only
// RULE2 - identity word never changes on any program or erase attempt
// RULE3 - configuration words sit at 8007h and 8008h
// RULE4 - calibration words at 8009h and 800ah survive every erase
// RULE5 - stack fault reset enable bit 9 of word two selects reset on stack fault
// RULE6 - regulator capacitor enable bit absent on low-power variants
// RULE7 - commands and data words travel least significant bit first
// RULE8 - sender changes data after rising clock, receiver samples on falling
// RULE9 - mode entry holds all other device logic in reset
// RULE10 - on entry all I/O float as inputs and address clears
// RULE11 - programming-supply-first: clock, data low, raise high voltage, then supply
// RULE12 - supply-first: clock, data low, supply on, then raise high voltage
// RULE13 - programming-supply-first entry is the recommended method
// RULE14 - high-voltage mode ends when master clear drops to supply level
// RULE15 - key entry accepted only while low-voltage enable bit is one
// RULE16 - low-voltage enable bit cleared only in a high-voltage session
// RULE17 - key entry: master clear low, then clock a 32-bit key
// RULE18 - key goes out starting with bit 0 of its lowest nibble
// RULE19 - master clear stays low for the whole low-voltage session
// RULE20 - low-voltage mode ends when master clear is released
// RULE21 - data command: delay, then 16 clocks: start, 14 data, stop
// RULE22 - identity word lives at 8006h, readable in programming mode
// RULE23 - device samples key bits on falling edges into a 32-bit register
// RULE24 - wrong key leaves device outside programming mode, nothing changed
module prog_entry_ctrl
  import prog_entry_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire prog_op_s          op_in,
  input  wire logic              op_valid_in,
  output logic                   op_ready_out,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_valid_in,
  output logic                   wr_ready_out,
  output logic [DATA_W-1:0]      rd_data_out,
  output logic                   rd_valid_out,
  output logic                   mode_active_out,
  output logic                   low_voltage_mode_out,
  output logic                   prog_clock_pin_out,
  output logic                   prog_data_pin_out,
  output logic                   prog_data_pin_oe_n_out,
  input  wire logic              prog_data_pin_in,
  output logic                   high_entry_voltage_en_out,
  output logic                   master_clear_pin_low_out,
  output logic                   supply_en_out
);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_PWR_A  = 4'h1,
    ST_PWR_B  = 4'h2,
    ST_KEY    = 4'h3,
    ST_ACTIVE = 4'h4,
    ST_CMD    = 4'h5,
    ST_DLY    = 4'h6,
    ST_DATA   = 4'h7,
    ST_GAP    = 4'h8,
    ST_EXIT   = 4'h9
  } ctl_state_e;

  typedef struct packed {
    ctl_state_e        st;
    prog_op_e          entry;
    logic [15:0]       wait_cnt;
    logic [7:0]        phase;
    logic [5:0]        bit_cnt;
    logic [5:0]        bit_last;
    logic [31:0]       tx;
    logic [15:0]       rx;
    logic              has_data;
    logic              is_read;
    logic [DATA_W-1:0] data_word;
    logic              pop;
    logic              op_ready;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic              active;
    logic              lv_mode;
    pin_drive_s        pins;
  } ctl_s;

  // pins idle: clock and data driven low, supplies off, master clear released
  localparam ctl_s CTL_RESET = '{
    st: ST_IDLE, entry: OP_ENTER_VPP_FIRST, wait_cnt: 16'h0000, phase: 8'h00,
    bit_cnt: 6'h00, bit_last: 6'h00, tx: 32'h00000000, rx: 16'h0000,
    has_data: 1'b0, is_read: 1'b0, data_word: 14'h0000, pop: 1'b0,
    op_ready: 1'b1, rd_valid: 1'b0, rd_data: 14'h0000, active: 1'b0,
    lv_mode: 1'b0,
    pins: '{clk: 1'b0, dat: 1'b0, dat_oe_n: 1'b0, vpp_en: 1'b0,
            master_clear_pin_low: 1'b0, vdd_en: 1'b0}
  };

  ctl_s              s;
  ctl_s              next_s;
  logic              dat_sync;
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              accept;
  logic              needs_word;

  prog_sync2 u_dat_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .d_in      (prog_data_pin_in),
    .q_out     (dat_sync)
  );

  prog_word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .in_data_in    (wr_data_in),
    .in_valid_in   (wr_valid_in),
    .in_ready_out  (wr_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (s.pop)
  );

  function automatic logic is_shift_state(input ctl_state_e st);
    return (st == ST_KEY) || (st == ST_CMD) || (st == ST_DATA);
  endfunction

  // a write command waits in place until its data word is buffered
  assign needs_word = (op_in.kind == OP_COMMAND) && op_in.has_data && !op_in.is_read;
  assign accept     = op_valid_in && s.op_ready && !(needs_word && !fifo_valid);

  always_comb begin
    next_s          = s;
    next_s.rd_valid = 1'b0;
    next_s.pop      = 1'b0;
    if (s.wait_cnt != 16'h0000) begin
      next_s.wait_cnt = s.wait_cnt - 16'h0001;
    end
    if (is_shift_state(s.st)) begin
      next_s.phase = s.phase + 8'h01;
      if (s.phase == 8'h00) begin
        next_s.pins.clk = 1'b1;
        next_s.pins.dat = s.tx[0]; // [RULE7] [RULE8] [RULE18]
      end else if (s.phase == PHASE_HALF) begin
        next_s.pins.clk = 1'b0;
        next_s.rx       = {dat_sync, s.rx[15:1]}; // [RULE8]
      end
      if (s.phase == PHASE_LAST) begin
        next_s.phase   = 8'h00;
        next_s.tx      = {1'b0, s.tx[31:1]};
        next_s.bit_cnt = s.bit_cnt + 6'h01;
      end
    end
    unique case (s.st)
      ST_IDLE: begin
        if (accept) begin
          next_s.entry    = op_in.kind;
          next_s.wait_cnt = WAIT_ENTRY;
          next_s.pins.clk = 1'b0; // [RULE11] [RULE12]
          next_s.pins.dat = 1'b0;
          next_s.pins.dat_oe_n = 1'b0;
          unique case (op_in.kind)
            OP_ENTER_VPP_FIRST: begin
              next_s.pins.vpp_en = 1'b1; // [RULE11] [RULE13]
              next_s.op_ready    = 1'b0;
              next_s.st          = ST_PWR_A;
            end
            OP_ENTER_VDD_FIRST, OP_ENTER_LOW_VOLT: begin
              next_s.pins.vdd_en = 1'b1; // [RULE12]
              next_s.op_ready    = 1'b0;
              next_s.st          = ST_PWR_A;
            end
            default: begin
              next_s.op_ready = 1'b1;
            end
          endcase
        end
      end
      ST_PWR_A: begin
        if (s.wait_cnt == 16'h0000) begin
          next_s.wait_cnt = WAIT_ENTRY;
          next_s.st       = ST_PWR_B;
          unique case (s.entry)
            OP_ENTER_VPP_FIRST: next_s.pins.vdd_en   = 1'b1; // [RULE11]
            OP_ENTER_VDD_FIRST: next_s.pins.vpp_en   = 1'b1; // [RULE12]
            default:            next_s.pins.master_clear_pin_low = 1'b1; // [RULE17]
          endcase
        end
      end
      ST_PWR_B: begin
        if (s.wait_cnt == 16'h0000) begin
          if (s.entry == OP_ENTER_LOW_VOLT) begin
            next_s.tx       = LV_ENTRY_KEY; // [RULE17] [RULE18]
            next_s.bit_cnt  = 6'h00;
            next_s.bit_last = KEY_LAST_BIT;
            next_s.phase    = 8'h00;
            next_s.st       = ST_KEY;
          end else begin
            next_s.active   = 1'b1;
            next_s.op_ready = 1'b1;
            next_s.st       = ST_ACTIVE;
          end
        end
      end
      ST_KEY: begin
        // no acknowledge exists; a refused key only shows in later reads
        if (s.phase == PHASE_LAST && s.bit_cnt == s.bit_last) begin
          next_s.pins.dat = 1'b0;
          next_s.lv_mode  = 1'b1; // [RULE19]
          next_s.active   = 1'b1;
          next_s.wait_cnt = WAIT_CMD_GAP;
          next_s.st       = ST_GAP;
        end
      end
      ST_ACTIVE: begin
        if (accept) begin
          next_s.op_ready = 1'b0;
          if (op_in.kind == OP_COMMAND) begin
            next_s.tx        = {26'h0000000, op_in.cmd}; // [RULE7]
            next_s.has_data  = op_in.has_data;
            next_s.is_read   = op_in.is_read;
            next_s.data_word = fifo_data;
            next_s.pop       = needs_word;
            next_s.bit_cnt   = 6'h00;
            next_s.bit_last  = CMD_LAST_BIT;
            next_s.phase     = 8'h00;
            next_s.st        = ST_CMD;
          end else if (op_in.kind == OP_EXIT) begin
            next_s.pins.vpp_en   = 1'b0; // [RULE14]
            next_s.pins.master_clear_pin_low = 1'b0; // [RULE20]
            next_s.wait_cnt      = WAIT_ENTRY;
            next_s.st            = ST_EXIT;
          end else begin
            next_s.op_ready = 1'b1;
          end
        end
      end
      ST_CMD: begin
        if (s.phase == PHASE_LAST && s.bit_cnt == s.bit_last) begin
          next_s.pins.dat = 1'b0;
          if (s.has_data) begin
            next_s.wait_cnt = WAIT_CMD_DATA; // [RULE21]
            next_s.st       = ST_DLY;
          end else begin
            next_s.wait_cnt = WAIT_CMD_GAP;
            next_s.st       = ST_GAP;
          end
        end
      end
      ST_DLY: begin
        if (s.wait_cnt == 16'h0000) begin
          next_s.tx            = {16'h0000, 1'b0, s.data_word, 1'b0}; // [RULE21]
          next_s.pins.dat_oe_n = s.is_read;
          next_s.bit_cnt       = 6'h00;
          next_s.bit_last      = FRAME_LAST_BIT;
          next_s.phase         = 8'h00;
          next_s.st            = ST_DATA;
        end
      end
      ST_DATA: begin
        if (s.phase == PHASE_LAST && s.bit_cnt == s.bit_last) begin
          next_s.pins.dat      = 1'b0;
          next_s.pins.dat_oe_n = 1'b0;
          next_s.rd_valid      = s.is_read;
          next_s.rd_data       = s.rx[DATA_W:1]; // [RULE21] [RULE7]
          next_s.wait_cnt      = WAIT_CMD_GAP;
          next_s.st            = ST_GAP;
        end
      end
      ST_GAP: begin
        if (s.wait_cnt == 16'h0000) begin
          next_s.op_ready = 1'b1;
          next_s.st       = ST_ACTIVE;
        end
      end
      ST_EXIT: begin
        if (s.wait_cnt == 16'h0000) begin
          next_s.pins.vdd_en = 1'b0;
          next_s.active      = 1'b0;
          next_s.lv_mode     = 1'b0;
          next_s.op_ready    = 1'b1;
          next_s.st          = ST_IDLE;
        end
      end
      default: begin
        next_s = CTL_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= CTL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign op_ready_out              = s.op_ready;
  assign rd_data_out               = s.rd_data;
  assign rd_valid_out              = s.rd_valid;
  assign mode_active_out           = s.active;
  assign low_voltage_mode_out      = s.lv_mode;
  assign prog_clock_pin_out        = s.pins.clk;
  assign prog_data_pin_out         = s.pins.dat;
  assign prog_data_pin_oe_n_out    = s.pins.dat_oe_n;
  assign high_entry_voltage_en_out = s.pins.vpp_en;
  assign master_clear_pin_low_out  = s.pins.master_clear_pin_low;
  assign supply_en_out             = s.pins.vdd_en;
endmodule

// >>> prog_entry_props.sv
`timescale 1ns/100ps
module prog_entry_props
  import prog_entry_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic rd_valid_out,
  input wire logic mode_active_out,
  input wire logic low_voltage_mode_out,
  input wire logic prog_clock_pin_out,
  input wire logic prog_data_pin_out,
  input wire logic prog_data_pin_oe_n_out,
  input wire logic high_entry_voltage_en_out,
  input wire logic master_clear_pin_low_out,
  input wire logic supply_en_out
);
  logic [5:0] key_edges;
  logic       clk_q;
  // rising serial edges seen while the key goes out
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      key_edges <= 6'h00;
      clk_q     <= 1'b0;
    end else begin
      clk_q <= prog_clock_pin_out;
      if (!master_clear_pin_low_out)
        key_edges <= 6'h00;
      else if (!mode_active_out && prog_clock_pin_out && !clk_q)
        key_edges <= key_edges + 6'h01;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_entry_quiet;
    (high_entry_voltage_en_out || supply_en_out) && !master_clear_pin_low_out
      && !mode_active_out |-> !prog_clock_pin_out && !prog_data_pin_out;
  endproperty
  a_entry_quiet: assert property (p_entry_quiet) else $error("pins not low at entry");
  property p_vpp_first;
    $rose(high_entry_voltage_en_out) && !supply_en_out |-> ##[1:600] supply_en_out;
  endproperty
  a_vpp_first: assert property (p_vpp_first) else $error("supply late after vpp");
  property p_supply_first;
    $rose(supply_en_out) && !high_entry_voltage_en_out
      |-> ##[1:600] (high_entry_voltage_en_out || master_clear_pin_low_out);
  endproperty
  a_supply_first: assert property (p_supply_first) else $error("no entry step");
  property p_fall_stable;
    $fell(prog_clock_pin_out) && !prog_data_pin_oe_n_out |-> $stable(prog_data_pin_out);
  endproperty
  a_fall_stable: assert property (p_fall_stable) else $error("data moved on fall");
  property p_clk_high;
    $rose(prog_clock_pin_out) |-> prog_clock_pin_out[*8] ##1 prog_clock_pin_out
      ##1 prog_clock_pin_out ##1 !prog_clock_pin_out;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock high time wrong");
  property p_rd_pulse;
    rd_valid_out |-> mode_active_out ##1 !rd_valid_out;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe wrong");
  property p_hv_exit;
    $fell(high_entry_voltage_en_out) |-> ##[1:600] !mode_active_out && !supply_en_out;
  endproperty
  a_hv_exit: assert property (p_hv_exit) else $error("session did not end");
  property p_lv_start;
    $rose(low_voltage_mode_out)
      |-> master_clear_pin_low_out && supply_en_out && !high_entry_voltage_en_out;
  endproperty
  a_lv_start: assert property (p_lv_start) else $error("key session pins wrong");
  property p_lv_exit;
    $fell(master_clear_pin_low_out) && low_voltage_mode_out
      |-> ##[1:600] !low_voltage_mode_out && !mode_active_out;
  endproperty
  a_lv_exit: assert property (p_lv_exit) else $error("key session did not end");
  property p_key_count;
    $rose(mode_active_out) && low_voltage_mode_out |-> key_edges == 6'h20;
  endproperty
  a_key_count: assert property (p_key_count) else $error("key length wrong");
endmodule
bind prog_entry_ctrl prog_entry_props props_u (.clk_in, .arst_n_in, .rd_valid_out,
  .mode_active_out, .low_voltage_mode_out, .prog_clock_pin_out, .prog_data_pin_out,
  .prog_data_pin_oe_n_out, .high_entry_voltage_en_out, .master_clear_pin_low_out,
  .supply_en_out);

// >>> prog_dev_model.sv
`timescale 1ns/100ps
module prog_dev_model
  import prog_entry_pkg::*;
#(
  parameter logic [8:0] PART_CODE = 9'h0c3, // arbitrary value
  parameter logic [4:0] REV_CODE  = 5'h02   // arbitrary value
)(
  input  wire logic clk_pin_in,
  input  wire logic dat_pin_in,
  input  wire logic vpp_in,
  input  wire logic vdd_in,
  input  wire logic master_clear_pin_low_in,
  output logic      dat_drv_out,
  output logic      dat_en_out,
  output logic      lv_mode_out
);
  logic [13:0] mem [0:10];
  logic [13:0] loads [$];
  logic [15:0] addr;
  logic [31:0] key;
  int          key_n;
  logic        hv_mode;
  logic        in_mode;
  assign hv_mode = vpp_in && vdd_in;
  assign in_mode = hv_mode || lv_mode_out;
  initial begin
    foreach (mem[i]) mem[i] = 14'h3fff;
    mem[6] = {PART_CODE, REV_CODE};
    dat_drv_out = 1'b0;
    dat_en_out = 1'b0;
    lv_mode_out = 1'b0;
    key_n = 0;
  end
  always @(posedge in_mode) addr = 16'h0000;
  always @(negedge clk_pin_in or negedge master_clear_pin_low_in) begin
    if (!master_clear_pin_low_in) begin
      lv_mode_out <= 1'b0;
      key_n = 0;
    end else if (!in_mode) begin
      key = {dat_pin_in, key[31:1]};
      key_n++;
      if (key_n == 32)
        lv_mode_out <= (key == LV_ENTRY_KEY) && mem[8][13];
    end
  end
  // bits outside a session are ignored, so key clocks never shift commands
  task automatic get_bits(input int n, output logic [15:0] v);
    int i;
    i = 0;
    v = '0;
    while (i < n) begin
      @(negedge clk_pin_in);
      if (in_mode) begin
        v[i] = dat_pin_in;
        i++;
      end
    end
  endtask
  task automatic send_frame(input logic [13:0] w);
    logic [15:0] f;
    f = {1'b0, w, 1'b0};
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_pin_in);
      dat_en_out = 1'b1;
      dat_drv_out = f[k];
    end
    @(negedge clk_pin_in);
    dat_en_out = 1'b0;
  endtask
  function automatic logic [13:0] rd_word(input logic [15:0] a);
    if (a >= ADDR_USER_ID && a <= ADDR_CALIB_TWO) return mem[a - ADDR_USER_ID];
    return 14'h0000;
  endfunction
  always begin
    logic [15:0] c;
    logic [15:0] d;
    wait (in_mode);
    get_bits(6, c);
    case (c[5:0])
      6'h00, 6'h02: begin
        get_bits(16, d);
        loads.push_back(d[14:1]);
        if (c[5:0] == 6'h00) addr = ADDR_USER_ID;
      end
      6'h04: send_frame(rd_word(addr));
      6'h06: addr = addr + 16'h0001;
      6'h16: addr = 16'h0000;
      default: ;
    endcase
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top
  import prog_entry_pkg::*;
  ;
  function automatic logic [13:0] id_word(input logic [8:0] part, input logic [4:0] rev);
    return {part, rev};
  endfunction
  logic              clk_in, arst_n_in, op_valid_in, op_ready_out, wr_valid_in, wr_ready_out;
  prog_op_s          op_in;
  logic [DATA_W-1:0] wr_data_in, rd_data_out, last_rd;
  logic              rd_valid_out, mode_active_out, low_voltage_mode_out, prog_clock_pin_out;
  logic              prog_data_pin_out, prog_data_pin_oe_n_out, prog_data_pin_in;
  logic              high_entry_voltage_en_out, master_clear_pin_low_out, supply_en_out;
  logic              drv, den, m_lv;
  logic              flt = 1'b0;
  logic [13:0]       words [8];
  int                mismatches, checks_done, cycles, rd_n;
  // released pin toggles so a stale level never reads as data
  assign prog_data_pin_in = !prog_data_pin_oe_n_out ? prog_data_pin_out : (den ? drv : flt);
  prog_entry_ctrl dut_u (.clk_in, .arst_n_in, .op_in, .op_valid_in, .op_ready_out,
    .wr_data_in, .wr_valid_in, .wr_ready_out, .rd_data_out, .rd_valid_out,
    .mode_active_out, .low_voltage_mode_out, .prog_clock_pin_out, .prog_data_pin_out,
    .prog_data_pin_oe_n_out, .prog_data_pin_in, .high_entry_voltage_en_out,
    .master_clear_pin_low_out, .supply_en_out);
  prog_dev_model #(.PART_CODE(9'h0c3), .REV_CODE(5'h02)) dev_u (
    .clk_pin_in(prog_clock_pin_out), .dat_pin_in(prog_data_pin_in),
    .vpp_in(high_entry_voltage_en_out), .vdd_in(supply_en_out),
    .master_clear_pin_low_in(master_clear_pin_low_out), .dat_drv_out(drv), .dat_en_out(den),
    .lv_mode_out(m_lv));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    flt <= ~flt;
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      summarize();
    end
  end
  always @(negedge clk_in) begin
    if (rd_valid_out === 1'b1) begin
      last_rd = rd_data_out;
      rd_n++;
    end
  end
  task automatic check_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_word(input string what, input logic [13:0] exp, input logic [13:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run_op(input prog_op_e k, input logic [5:0] c, input logic hd, input logic rd);
    op_in = '{kind: k, cmd: c, has_data: hd, is_read: rd};
    op_valid_in = 1'b1;
    do @(negedge clk_in); while (op_ready_out !== 1'b1);
    @(posedge clk_in);
    #1 op_valid_in = 1'b0;
    repeat (3) @(negedge clk_in);
    for (int i = 0; i < 3000 && op_ready_out !== 1'b1; i++) @(negedge clk_in);
    check_bit("op_ready", 1'b1, op_ready_out);
    @(posedge clk_in);
    #1;
  endtask
  task automatic fill(input int n);
    wr_valid_in = 1'b1;
    for (int i = 0; i < n; i++) begin
      words[i] = (i == 0) ? 14'h3fff : (i == 1) ? 14'h0000 : 14'($urandom);
      wr_data_in = words[i];
      do @(negedge clk_in); while (wr_ready_out !== 1'b1);
      @(posedge clk_in);
      #1;
    end
    wr_valid_in = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    int seed;
    arst_n_in = 1'b0;
    op_in = '0;
    op_valid_in = 1'b0;
    wr_valid_in = 1'b0;
    wr_data_in = '0;
    seed = $urandom(20);
    repeat (12) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    check_bit("oe_n at reset", 1'b0, prog_data_pin_oe_n_out);
    run_op(OP_COMMAND, 6'h06, 1'b0, 1'b0);
    check_bit("idle command dropped", 1'b0, supply_en_out);
    run_op(OP_ENTER_VPP_FIRST, 6'h00, 1'b0, 1'b0);
    check_bit("vpp session", 1'b1, mode_active_out);
    fill(8);
    check_bit("fifo refuses when full", 1'b0, wr_ready_out);
    repeat (8) run_op(OP_COMMAND, 6'h02, 1'b1, 1'b0);
    foreach (words[i]) check_word("loaded word", words[i], dev_u.loads[i]);
    fill(1);
    run_op(OP_COMMAND, 6'h00, 1'b1, 1'b0);
    check_word("load count", 14'd9, 14'(dev_u.loads.size()));
    repeat (6) run_op(OP_COMMAND, 6'h06, 1'b0, 1'b0);
    run_op(OP_COMMAND, 6'h04, 1'b1, 1'b1);
    check_word("identity word", id_word(9'h0c3, 5'h02), last_rd);
    run_op(OP_COMMAND, 6'h06, 1'b0, 1'b0);
    run_op(OP_COMMAND, 6'h04, 1'b1, 1'b1);
    check_word("config one", 14'h3fff, last_rd);
    check_word("read count", 14'd2, 14'(rd_n));
    run_op(OP_EXIT, 6'h00, 1'b0, 1'b0);
    check_bit("vpp exit", 1'b0, mode_active_out);
    run_op(OP_ENTER_VDD_FIRST, 6'h00, 1'b0, 1'b0);
    check_bit("vdd session", 1'b1, mode_active_out);
    run_op(OP_EXIT, 6'h00, 1'b0, 1'b0);
    check_bit("vdd exit", 1'b0, supply_en_out);
    run_op(OP_ENTER_LOW_VOLT, 6'h00, 1'b0, 1'b0);
    check_bit("key session", 1'b1, low_voltage_mode_out);
    check_bit("key accepted", 1'b1, m_lv);
    arst_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    check_bit("reset ends session", 1'b0, mode_active_out);
    check_bit("reset releases clear", 1'b0, m_lv);
    run_op(OP_ENTER_LOW_VOLT, 6'h00, 1'b0, 1'b0);
    run_op(OP_ENTER_VPP_FIRST, 6'h00, 1'b0, 1'b0);
    check_bit("no vpp in key session", 1'b0, high_entry_voltage_en_out);
    run_op(OP_EXIT, 6'h00, 1'b0, 1'b0);
    check_bit("key exit", 1'b0, low_voltage_mode_out);
    check_bit("device left mode", 1'b0, m_lv);
    summarize();
  end
endmodule
